/* bench/pmmux_periph_model.sv */
// Stand-in for the CAN and serial controllers beside port M pins 3..0.
// Assumes the bench gives enables, drive choices and line levels every cycle.
module pmmux_periph_model
  import pmmux_pkg::*;
(
  input wire logic [9:0] ctrl,
  output pmmux_periph_t periph
);
  // ============================================================
  // Controller outputs
  // A switched-off transmitter idles high, so a stale level never looks like data.
  always_comb begin
    periph = pmmux_periph_t'(ctrl);
    if (!periph.canEn) periph.canTx = 1'b1;
    if (!periph.serialATxEn) periph.serialATx = 1'b1;
    if (!periph.serialBTxEn) periph.serialBTx = 1'b1;
  end
endmodule : pmmux_periph_model

/* bench/tb.sv */
// Self-checking bench: all four package variants side by side on one stimulus.
// Assumes the register map and the one-cycle pin latency of the multiplexer.
module tb
  import pmmux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Signals
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  pmmux_axil_req_t req = '0;
  logic [9:0] ctrl = '0;
  logic [3:0] pinIn = '0;
  pmmux_periph_t periph;
  pmmux_axil_rsp_t rsp[4];
  pmmux_rx_t rx[4];
  logic [3:0] pOut[4], oeN[4], pe[4], pp[4];
  logic [3:0] eOe, eOut, ePe;
  logic [2:0] eRx;
  logic [15:0] lf = 16'h3bf2;
  int regs[4] = '{0, 0, 0, 0};
  int miscompares = 0;
  int checksDone = 0;
  always #4 clock = ~clock;
  pmmux_periph_model part_u(.ctrl(ctrl), .periph(periph));
  for (genvar v = 0; v < 4; v++) begin : g
    pmmux #(.PKG_VARIANT(pmmux_variant_t'(v)), .ADDR_W(8)) dut_u(.clock(clock), .arst_n(arst_n),
      .axiReq(req), .axiRsp(rsp[v]), .periph(periph), .periphRx(rx[v]), .pinIn(pinIn),
      .pinOut(pOut[v]), .pinOeN(oeN[v]), .pullEnable(pe[v]), .pullPolarity(pp[v]));
  end
  // ============================================================
  // Helpers
  function automatic logic [15:0] lfsrNext(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsrNext
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks=%0d mismatches=%0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task bail;
    miscompares++;
    finish_test();
  endtask : bail
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] eResp,
      input logic [3:0] s);
    int n;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      if (rsp[0].awready) req.awvalid <= 1'b0;
      if (rsp[0].wready) req.wvalid <= 1'b0;
      n++;
      if (n > 50) bail();
    end while (rsp[0].bvalid !== 1'b1);
    req.bready <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      chk(rsp[v].bresp, eResp);
    end
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] eD, input logic [1:0] eResp);
    int n;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    req.rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      if (rsp[0].arready) req.arvalid <= 1'b0;
      n++;
      if (n > 50) bail();
    end while (rsp[0].rvalid !== 1'b1);
    req.rready <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      chk(rsp[v].rdata, eD);
      chk(rsp[v].rresp, eResp);
    end
  endtask : rd
  // ============================================================
  // Reference model of one variant; CAN wins pins 0 and 1 over any serial use.
  task model(input int v);
    logic can;
    can = periph.canEn && v != 0;
    eOe = ~regs[1][3:0];
    eOut = regs[0][3:0];
    ePe = regs[2][3:0];
    eRx = 3'b111;
    if (v == 3 && periph.serialBTxEn) begin
      {eOe[3], eOut[3]} = {!periph.serialBTxDrive, periph.serialBTx};
    end
    if (v == 3 && periph.serialBRxEn) {eOe[2], eRx[0]} = {1'b1, pinIn[2]};
    if (can) begin
      {eOe[1], eOut[1], eOe[0], eRx[2], ePe[0]} = {1'b0, periph.canTx, 1'b1, pinIn[0], 1'b0};
    end else begin
      if (v == 1 && periph.serialATxEn) begin
        {eOe[1], eOut[1]} = {!periph.serialATxDrive, periph.serialATx};
      end
      if (v == 2 && periph.serialBTxEn) begin
        {eOe[1], eOut[1]} = {!periph.serialBTxDrive, periph.serialBTx};
      end
      if (v == 1 && periph.serialARxEn) {eOe[0], eRx[1]} = {1'b1, pinIn[0]};
      if (v == 2 && periph.serialBRxEn) {eOe[0], eRx[0]} = {1'b1, pinIn[0]};
    end
  endtask : model
  task cmpAll;
    for (int v = 0; v < 4; v++) begin
      model(v);
      chk(~oeN[v] & pOut[v], ~eOe & eOut);
      chk(oeN[v], eOe);
      chk(rx[v], eRx);
      chk(pe[v], ePe);
      chk(pp[v], regs[3][3:0]);
    end
  endtask : cmpAll
  // ============================================================
  // Main sequence
  initial begin
    logic [1:0] k;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    cmpAll();
    chk(pp[3], 4'h0);
    for (int i = 0; i < 400; i++) begin
      lf = lfsrNext(lf);
      if (i % 16 == 0) begin
        k = lf[1:0];
        regs[k] = lf[15:12];
        wr({4'h0, k, 2'b00}, {28'h0, lf[15:12]}, 2'h0, 4'hf);
        rd({4'h0, k, 2'b00}, {28'h0, lf[15:12]}, 2'h0);
        lf = lfsrNext(lf);
      end
      @(posedge clock);
      ctrl <= lf[9:0];
      pinIn <= lf[15:12];
      @(posedge clock);
      @(negedge clock);
      cmpAll();
    end
    // A write without lane 0 is answered but changes nothing.
    wr(8'h00, 32'ha, 2'h0, 4'h0);
    rd(8'h00, regs[0], 2'h0);
    // All pulls on and no peripheral: status shows the pins and no owner.
    regs[2] = 15;
    wr(8'h08, 32'hf, 2'h0, 4'hf);
    @(posedge clock);
    ctrl <= '0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmpAll();
    rd(8'h10, {28'h0, pinIn}, 2'h0);
    // Unmapped place: refused and left without effect.
    wr(8'h20, 32'h5, 2'h2, 4'hf);
    rd(8'h20, 32'h0, 2'h2);
    // A second reset must drop every software pull choice again.
    @(posedge clock);
    arst_n <= 1'b0;
    regs = '{0, 0, 0, 0};
    repeat (2) @(posedge clock);
    @(negedge clock);
    for (int v = 0; v < 4; v++) begin
      chk(pe[v], 4'h0);
      chk(oeN[v], 4'hf);
    end
    @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    cmpAll();
    finish_test();
  end
endmodule : tb

/* src/pmmux.sv */
// Port M pins 3..0 multiplexer with its AXI4-Lite register slave.
// Assumes synchronous pin inputs and peripheral enables from on-chip controllers.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "pmmux_consts.svh"
module pmmux
  import pmmux_pkg::*;
#(
  parameter pmmux_variant_t PKG_VARIANT = PMMUX_PKG64,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire pmmux_axil_req_t axiReq,
  output pmmux_axil_rsp_t axiRsp,
  input wire pmmux_periph_t periph,
  output pmmux_rx_t periphRx,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOeN,
  output logic [3:0] pullEnable,
  output logic [3:0] pullPolarity
);
  // ============================================================
  // Elaboration checks
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 32");
  end

  localparam logic IS20 = (PKG_VARIANT == PMMUX_PKG20);
  localparam logic IS32 = (PKG_VARIANT == PMMUX_PKG32);
  localparam logic IS48 = (PKG_VARIANT == PMMUX_PKG48);
  localparam logic IS64 = (PKG_VARIANT == PMMUX_PKG64);

  pmmux_state_t q;
  pmmux_state_t d;
  logic [3:0] pOut;
  logic [3:0] pOeN;
  logic [3:0] own;
  logic [7:0] rdAddr;
  logic wrHit;

  // ============================================================
  // Pin ownership and routing
  always_comb begin
    // Unowned pins fall back to GPIO; the loop covers every bit alike.
    for (int i = 0; i < 4; i++) begin
      pOut[i] = q.gpoData[i];
      pOeN[i] = ~q.gpoDir[i];
    end
    own = 4'h0;
    if (IS64 && periph.serialBTxEn) begin
      own[3] = 1'b1;
      pOut[3] = periph.serialBTx;
      pOeN[3] = ~periph.serialBTxDrive;
    end
    if (IS64 && periph.serialBRxEn) begin
      own[2] = 1'b1;
      pOeN[2] = 1'b1;
    end
    if (!IS20 && periph.canEn) begin
      own[1:0] = 2'h3;
      pOut[1] = periph.canTx;
      pOeN[1] = 1'b0;
      pOeN[0] = 1'b1;
    end else begin
      if (IS32 && periph.serialATxEn) begin
        own[1] = 1'b1;
        pOut[1] = periph.serialATx;
        pOeN[1] = ~periph.serialATxDrive;
      end else if (IS48 && periph.serialBTxEn) begin
        own[1] = 1'b1;
        pOut[1] = periph.serialBTx;
        pOeN[1] = ~periph.serialBTxDrive;
      end
      if (IS32 && periph.serialARxEn) begin
        own[0] = 1'b1;
        pOeN[0] = 1'b1;
      end else if (IS48 && periph.serialBRxEn) begin
        own[0] = 1'b1;
        pOeN[0] = 1'b1;
      end
    end
  end

  // ============================================================
  // Next state: register slave and registered pin outputs
  always_comb begin
    d = q;
    d.pinOut = pOut;
    d.pinOeN = pOeN;
    d.owned = own;
    d.pullPolOut = q.pullPol;
    d.pullEnOut = q.pullEn;
    if (!IS20 && periph.canEn) begin
      d.pullEnOut[0] = 1'b0;
    end
    d.rx.canRx = (!IS20 && periph.canEn) ? pinIn[0] : `PMMUX_IDLE_RX;
    d.rx.serialARx = `PMMUX_IDLE_RX;
    if (IS32 && own[0] && !periph.canEn) begin
      d.rx.serialARx = pinIn[0];
    end
    d.rx.serialBRx = `PMMUX_IDLE_RX;
    if (IS64 && periph.serialBRxEn) begin
      d.rx.serialBRx = pinIn[2];
    end else if (IS48 && own[0] && !periph.canEn) begin
      d.rx.serialBRx = pinIn[0];
    end
    // Write channel: address and data are taken in either order.
    if (axiReq.awvalid && q.rsp.awready) begin
      d.haveAw = 1'b1;
      d.awAddr = axiReq.awaddr[7:0];
    end
    if (axiReq.wvalid && q.rsp.wready) begin
      d.haveW = 1'b1;
      d.wData = axiReq.wdata[3:0];
      d.wLane0 = axiReq.wstrb[0];
    end
    wrHit = 1'b1;
    if (q.haveAw && q.haveW && !q.rsp.bvalid) begin
      d.haveAw = 1'b0;
      d.haveW = 1'b0;
      d.rsp.bvalid = 1'b1;
      unique case (q.awAddr)
        `PMMUX_OFS_DATA: if (q.wLane0) d.gpoData = q.wData;
        `PMMUX_OFS_DIR: if (q.wLane0) d.gpoDir = q.wData;
        `PMMUX_OFS_PULLEN: if (q.wLane0) d.pullEn = q.wData;
        `PMMUX_OFS_PULLPOL: if (q.wLane0) d.pullPol = q.wData;
        default: wrHit = 1'b0;
      endcase
      d.rsp.bresp = wrHit ? `PMMUX_RESP_OKAY : `PMMUX_RESP_SLVERR;
    end else if (q.rsp.bvalid && axiReq.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    // Ready is withheld while a response waits, so at most one write is in flight.
    d.rsp.awready = !d.haveAw && !d.rsp.bvalid;
    d.rsp.wready = !d.haveW && !d.rsp.bvalid;
    // Read channel: data answers on the edge that takes the address.
    rdAddr = axiReq.araddr[7:0];
    if (axiReq.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = `PMMUX_RESP_OKAY;
      d.rsp.rdata = 32'h0;
      unique case (rdAddr)
        `PMMUX_OFS_DATA: d.rsp.rdata[3:0] = q.gpoData;
        `PMMUX_OFS_DIR: d.rsp.rdata[3:0] = q.gpoDir;
        `PMMUX_OFS_PULLEN: d.rsp.rdata[3:0] = q.pullEn;
        `PMMUX_OFS_PULLPOL: d.rsp.rdata[3:0] = q.pullPol;
        `PMMUX_OFS_STATUS: begin
          d.rsp.rdata[3:0] = pinIn;
          d.rsp.rdata[`PMMUX_STAT_OWN_LSB +: 4] = q.owned;
        end
        default: d.rsp.rresp = `PMMUX_RESP_SLVERR;
      endcase
    end else if (q.rsp.rvalid && axiReq.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.gpoData <= `PMMUX_RST_FIELD;
      q.gpoDir <= `PMMUX_RST_FIELD;
      q.pullEn <= `PMMUX_RST_FIELD;
      q.pullPol <= `PMMUX_RST_FIELD;
      q.pinOeN <= 4'hf;
      q.rx <= '1;
    end else begin
      q <= d;
    end
  end

  assign axiRsp = q.rsp;
  assign periphRx = q.rx;
  assign pinOut = q.pinOut;
  assign pinOeN = q.pinOeN;
  assign pullEnable = q.pullEnOut;
  assign pullPolarity = q.pullPolOut;

  // ============================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_pin3_sertx: assert property (IS64 && periph.serialBTxEn |=>
      pinOut[3] == $past(periph.serialBTx) && pinOeN[3] == !$past(periph.serialBTxDrive))
    else $error("pin 3 does not follow serial B transmit");
  chk_pin2_serrx: assert property (IS64 && periph.serialBRxEn |=>
      pinOeN[2] && periphRx.serialBRx == $past(pinIn[2]))
    else $error("pin 2 is not serial B receive input");
  chk_pin1_cantx: assert property (!IS20 && periph.canEn |=>
      !pinOeN[1] && pinOut[1] == $past(periph.canTx))
    else $error("pin 1 is not driven by CAN transmit");
  chk_pin1_seratx: assert property (IS32 && !periph.canEn && periph.serialATxEn |=>
      pinOut[1] == $past(periph.serialATx) && pinOeN[1] == !$past(periph.serialATxDrive))
    else $error("pin 1 does not follow serial A transmit");
  chk_pin1_serbtx: assert property (IS48 && !periph.canEn && periph.serialBTxEn |=>
      pinOut[1] == $past(periph.serialBTx) && pinOeN[1] == !$past(periph.serialBTxDrive))
    else $error("pin 1 does not follow serial B transmit");
  chk_pin0_canrx: assert property (!IS20 && periph.canEn |=>
      pinOeN[0] && periphRx.canRx == $past(pinIn[0]))
    else $error("pin 0 is not CAN receive input");
  chk_pin0_nopull: assert property (!IS20 && periph.canEn |=> !pullEnable[0])
    else $error("pull on pin 0 active while CAN owns it");
  chk_pin0_serarx: assert property (IS32 && !periph.canEn && periph.serialARxEn |=>
      pinOeN[0] && periphRx.serialARx == $past(pinIn[0]))
    else $error("pin 0 is not serial A receive input");
  chk_pin0_serbrx: assert property (IS48 && !periph.canEn && periph.serialBRxEn |=>
      pinOeN[0] && periphRx.serialBRx == $past(pinIn[0]))
    else $error("pin 0 is not serial B receive input");
  chk_pin3_gpio: assert property (!(IS64 && periph.serialBTxEn) |=>
      pinOut[3] == $past(q.gpoData[3]) && pinOeN[3] == !$past(q.gpoDir[3]))
    else $error("free pin 3 does not follow GPIO");
  chk_pull_fromsw: assert property (pullEnable != 4'h0 |-> $past(q.pullEn) != 4'h0)
    else $error("pull enabled without software request");

  cov_can_owns: cover property (periph.canEn ##1 !pinOeN[1]);
  cov_write_done: cover property (axiRsp.bvalid && axiReq.bready);
  cov_read_done: cover property (axiRsp.rvalid && axiReq.rready);
  cov_gpio_drive: cover property (own == 4'h0 && q.gpoDir != 4'h0);
endmodule : pmmux

/* src/pmmux_consts.svh */
// Constants of the port M low-pin signal multiplexer.
// Assumes inclusion by the package and the multiplexer module only.
// Functional notes
// - In 64/100-pin packages pin 3 carries serial B transmit when enabled, above GPIO.
// - In 64/100-pin packages pin 2 is serial B receive input when enabled, above GPIO.
// - Outside the 20-pin package an enabled CAN drives its transmit out on pin 1 first.
// - In the 32-pin package pin 1 carries serial A transmit after CAN, before GPIO.
// - In the 48-pin package pin 1 carries serial B transmit after CAN, before GPIO.
// - Outside the 20-pin package an enabled CAN takes pin 0 as input for its receive.
// - While CAN owns pin 0 the pulldown selection on that pin has no effect.
// - In the 32-pin package pin 0 is serial A receive input after CAN, before GPIO.
// - In the 48-pin package pin 0 is serial B receive input after CAN, before GPIO.
`ifndef PMMUX_CONSTS_SVH
`define PMMUX_CONSTS_SVH
// ============================================================
// Register offsets
`define PMMUX_OFS_DATA 8'h00
`define PMMUX_OFS_DIR 8'h04
`define PMMUX_OFS_PULLEN 8'h08
`define PMMUX_OFS_PULLPOL 8'h0c
`define PMMUX_OFS_STATUS 8'h10
// ============================================================
// Field positions, reset values and answers
`define PMMUX_STAT_OWN_LSB 4
`define PMMUX_RST_FIELD 4'h0
`define PMMUX_IDLE_RX 1'b1
`define PMMUX_RESP_OKAY 2'h0
`define PMMUX_RESP_SLVERR 2'h2
`endif

/* src/pmmux_pkg.sv */
// Types of the port M low-pin signal multiplexer.
// Assumes the constants header is on the include path.
`include "pmmux_consts.svh"
package pmmux_pkg;
  typedef enum logic [1:0] {
    PMMUX_PKG20 = 2'b00,
    PMMUX_PKG32 = 2'b01,
    PMMUX_PKG48 = 2'b10,
    PMMUX_PKG64 = 2'b11
  } pmmux_variant_t;
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } pmmux_axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmmux_axil_rsp_t;
  typedef struct packed {
    logic canEn;
    logic canTx;
    logic serialATxEn;
    logic serialATx;
    logic serialATxDrive;
    logic serialARxEn;
    logic serialBTxEn;
    logic serialBTx;
    logic serialBTxDrive;
    logic serialBRxEn;
  } pmmux_periph_t;
  typedef struct packed {
    logic canRx;
    logic serialARx;
    logic serialBRx;
  } pmmux_rx_t;
  typedef struct packed {
    logic haveAw;
    logic haveW;
    logic [7:0] awAddr;
    logic [3:0] wData;
    logic wLane0;
    logic [3:0] gpoData;
    logic [3:0] gpoDir;
    logic [3:0] pullEn;
    logic [3:0] pullPol;
    pmmux_axil_rsp_t rsp;
    logic [3:0] pinOut;
    logic [3:0] pinOeN;
    logic [3:0] pullEnOut;
    logic [3:0] pullPolOut;
    logic [3:0] owned;
    pmmux_rx_t rx;
  } pmmux_state_t;
endpackage : pmmux_pkg
